// ===== design/preset_counter_output.sv
// Purpose: Preset counter with switching output on pin 1 and reset input on pin 2.
// Assumes: count_pulse_i is a one-cycle event from logic on sys_clk_i.
// Notes: Pin 1 doubles as the IO-Link line while iol_mode_i is high.
// Notes on behaviour
// - Static mode: output goes active at preset and stays until counter reset.
// - Pulse mode: output goes active at preset, idles after pulse length.
// - Pulse length 0.1 to 100.0 s, used only in pulse mode.
// - Positive polarity drives high when active in push-pull and releases the line in open-drain; negative drives low when active.
// - The counter reset input exists only on pin 2.
// - Rising-edge mode clears the count on each rising edge, then counts on.
// - Falling-edge mode clears the count on each falling edge, then counts on.
// - High-level mode holds count at zero while input high.
// - Low-level mode holds count at zero while input low.
// - Inversion function drives pin 2 as complement of pin 1.
// - In IO-Link mode pin 1 is the line; counter output is off.
// - In IO-Link mode settings except the interrupt mask come from the IO-Link port only; the mask is written only from the manual port.
// - Pin 2 pulled to ground while driven high reports a short fault.
// - The preset counter output exists only on pin 1.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module preset_counter_output #(
    parameter int TICK_CYCLES = preset_counter_pkg::TENTH_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [preset_counter_pkg::ADDR_W-1:0] addr_i,
    input wire logic [preset_counter_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [preset_counter_pkg::DATA_W-1:0] rdata_o,
    input wire logic [preset_counter_pkg::ADDR_W-1:0] iol_addr_i,
    input wire logic [preset_counter_pkg::DATA_W-1:0] iol_wdata_i,
    input wire logic iol_wr_i,
    input wire logic iol_mode_i,
    input wire logic iol_tx_i,
    input wire logic iol_txen_i,
    output logic iol_rx_o,
    input wire logic count_pulse_i,
    input wire logic pin1_i,
    output logic pin1_o,
    output logic pin1_oe_o,
    input wire logic pin2_i,
    output logic pin2_o,
    output logic pin2_oe_o,
    output logic irq_o
);
    import preset_counter_pkg::*;

    cfg_s cfg_reg;
    logic [CNT_W-1:0] preset_reg;
    logic [LEN_W-1:0] len_reg;
    logic [CNT_W-1:0] count_reg;
    logic hit_done_reg;
    out_state_e state_reg;
    out_state_e state_next;
    logic [STAT_W-1:0] status_reg;
    logic [STAT_W-1:0] mask_reg;
    logic [31:0] short_cnt_reg;
    logic short_reg;
    pin_sense_s sense;
    logic cfg_wr;
    logic [ADDR_W-1:0] cfg_addr;
    logic [DATA_W-1:0] cfg_data;
    logic ctr_clear;
    logic ctr_hold;
    logic hit;
    logic timer_start;
    logic timer_abort;
    logic timer_done;
    logic active;
    logic out_level;
    logic [STAT_W-1:0] events;
    logic status_rd;

    function automatic logic [LEN_W-1:0] clamp_len(input logic [DATA_W-1:0] v);
        if (v < DATA_W'(LEN_MIN)) begin
            return LEN_MIN;
        end else if (v > DATA_W'(LEN_MAX)) begin
            return LEN_MAX;
        end
        return v[LEN_W-1:0];
    endfunction

    pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i({pin2_i, pin1_i}),
        .sense_o(sense)
    );

    // In IO-Link mode the manual port is locked out so a stale write cannot win.
    always_comb begin
        if (iol_mode_i) begin
            cfg_wr = iol_wr_i;
            cfg_addr = iol_addr_i;
            cfg_data = iol_wdata_i;
        end else begin
            cfg_wr = wr_i;
            cfg_addr = addr_i;
            cfg_data = wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= CFG_RESET;
            preset_reg <= PRESET_RESET;
            len_reg <= LEN_RESET;
        end else if (cfg_wr) begin
            if (cfg_addr == OFF_CTRL) begin
                cfg_reg <= cfg_s'(cfg_data[CFG_W-1:0]);
            end
            if (cfg_addr == OFF_PRESET) begin
                preset_reg <= cfg_data;
            end
            if (cfg_addr == OFF_PULSE_LEN) begin
                len_reg <= clamp_len(cfg_data);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mask_reg <= '0;
        end else if (wr_i && addr_i == OFF_MASK) begin
            mask_reg <= wdata_i[STAT_W-1:0];
        end
    end

    // Only pin 2 carries the reset input; pin 1 never feeds the counter.
    always_comb begin
        ctr_clear = 1'b0;
        ctr_hold = 1'b0;
        if (cfg_reg.pin2_fn == PIN2_RESET) begin
            unique case (cfg_reg.rst_mode)
                RST_RISE: ctr_clear = sense.rise[1];
                RST_FALL: ctr_clear = sense.fall[1];
                RST_HIGH: ctr_hold = sense.level[1];
                RST_LOW: ctr_hold = ~sense.level[1];
            endcase
        end
    end

    // The count saturates rather than wrapping, so a missed reset cannot re-fire the hit.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else if (ctr_clear || ctr_hold) begin
            count_reg <= '0;
        end else if (count_pulse_i && count_reg != '1) begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    assign hit = (count_reg >= preset_reg) && !hit_done_reg && !ctr_clear && !ctr_hold;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hit_done_reg <= 1'b0;
        end else if (ctr_clear || ctr_hold) begin
            hit_done_reg <= 1'b0;
        end else if (hit) begin
            hit_done_reg <= 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        timer_start = 1'b0;
        timer_abort = 1'b0;
        unique case (state_reg)
            OUT_IDLE: begin
                if (hit && cfg_reg.pin1_preset && !iol_mode_i) begin
                    if (cfg_reg.pulse_mode) begin
                        state_next = OUT_PULSE;
                        timer_start = 1'b1;
                    end else begin
                        state_next = OUT_LATCH;
                    end
                end
            end
            OUT_LATCH: begin
                if (ctr_clear || ctr_hold || iol_mode_i || !cfg_reg.pin1_preset) begin
                    state_next = OUT_IDLE;
                end
            end
            OUT_PULSE: begin
                if (iol_mode_i || !cfg_reg.pin1_preset) begin
                    state_next = OUT_IDLE;
                    timer_abort = 1'b1;
                end else if (timer_done) begin
                    state_next = OUT_IDLE;
                end
            end
            default: state_next = OUT_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= OUT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    pulse_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(timer_start),
        .abort_i(timer_abort),
        .len_i(len_reg),
        .done_o(timer_done)
    );

    assign active = (state_reg != OUT_IDLE);
    assign out_level = active ^ cfg_reg.pol_neg;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin1_o <= 1'b0;
            pin1_oe_o <= 1'b0;
            iol_rx_o <= 1'b0;
        end else begin
            iol_rx_o <= sense.level[0];
            if (iol_mode_i) begin
                pin1_o <= iol_tx_i;
                pin1_oe_o <= iol_txen_i;
            end else if (cfg_reg.pin1_preset) begin
                pin1_o <= out_level;
                // Open-drain drives only the low level; push-pull drives both.
                pin1_oe_o <= cfg_reg.pin1_pp | ~out_level;
            end else begin
                pin1_o <= 1'b0;
                pin1_oe_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin2_o <= 1'b0;
            pin2_oe_o <= 1'b0;
        end else if (cfg_reg.pin2_fn == PIN2_INVERT && !iol_mode_i) begin
            pin2_o <= ~out_level;
            pin2_oe_o <= 1'b1;
        end else begin
            pin2_o <= 1'b0;
            pin2_oe_o <= 1'b0;
        end
    end

    // A driven-high pin 2 that reads low for the whole window is shorted to ground.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            short_cnt_reg <= 32'h0000_0000;
            short_reg <= 1'b0;
        end else if (pin2_oe_o && pin2_o && !sense.level[1]) begin
            if (short_cnt_reg == 32'(SHORT_CYCLES - 1)) begin
                short_reg <= 1'b1;
            end else begin
                short_cnt_reg <= short_cnt_reg + 32'h0000_0001;
            end
        end else begin
            short_cnt_reg <= 32'h0000_0000;
            short_reg <= 1'b0;
        end
    end

    always_comb begin
        events = '0;
        events[STAT_HIT] = hit && cfg_reg.pin1_preset && !iol_mode_i;
        events[STAT_PEND] = timer_done;
        events[STAT_CLR] = ctr_clear;
        // The event needs the short to persist, so it fires only with the flag it sets.
        events[STAT_SHORT] = pin2_oe_o && pin2_o && !sense.level[1] && !short_reg
            && (short_cnt_reg == 32'(SHORT_CYCLES - 1));
    end

    assign status_rd = rd_i && addr_i == OFF_STATUS;

    // Set wins over the read-clear so an event in the read cycle survives.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            status_reg <= '0;
            irq_o <= 1'b0;
        end else begin
            status_reg <= (status_rd ? '0 : status_reg) | events;
            irq_o <= |(((status_rd ? '0 : status_reg) | events) & mask_reg);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                OFF_CTRL: rdata_o <= DATA_W'(cfg_reg);
                OFF_PRESET: rdata_o <= preset_reg;
                OFF_PULSE_LEN: rdata_o <= DATA_W'(len_reg);
                OFF_COUNT: rdata_o <= count_reg;
                OFF_STATUS: rdata_o <= DATA_W'(status_reg);
                OFF_MASK: rdata_o <= DATA_W'(mask_reg);
                OFF_PINS: rdata_o <= DATA_W'({short_reg, sense.level, pin2_o, pin1_o, active});
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence no_clear;
        !ctr_clear && !ctr_hold;
    endsequence

    sequence latched_out;
        state_reg == OUT_LATCH && !iol_mode_i && cfg_reg.pin1_preset;
    endsequence

    latch_hold_a: assert property (
        latched_out ##0 no_clear |=> state_reg == OUT_LATCH)
        else $error("Static output dropped without a counter reset.");

    pulse_end_a: assert property (
        state_reg == OUT_PULSE && timer_done |=> state_reg == OUT_IDLE)
        else $error("Pulse output did not return to idle at pulse end.");

    len_range_a: assert property (
        len_reg >= LEN_MIN && len_reg <= LEN_MAX)
        else $error("Pulse length outside 0.1 to 100.0 seconds.");

    pin_polarity_a: assert property (
        !$past(iol_mode_i) && $past(cfg_reg.pin1_preset) |-> pin1_o == $past(out_level))
        else $error("Pin 1 level does not match output state and polarity.");

    rise_clear_a: assert property (
        cfg_reg.pin2_fn == PIN2_RESET && cfg_reg.rst_mode == RST_RISE && sense.rise[1]
        |=> count_reg == '0)
        else $error("Rising edge did not clear the counter.");

    fall_clear_a: assert property (
        cfg_reg.pin2_fn == PIN2_RESET && cfg_reg.rst_mode == RST_FALL && sense.fall[1]
        |=> count_reg == '0)
        else $error("Falling edge did not clear the counter.");

    high_hold_a: assert property (
        cfg_reg.pin2_fn == PIN2_RESET && cfg_reg.rst_mode == RST_HIGH && sense.level[1]
        |=> count_reg == '0)
        else $error("Counter not held at zero while input high.");

    low_hold_a: assert property (
        cfg_reg.pin2_fn == PIN2_RESET && cfg_reg.rst_mode == RST_LOW && !sense.level[1]
        |=> count_reg == '0)
        else $error("Counter not held at zero while input low.");

    pin2_invert_a: assert property (
        $past(cfg_reg.pin2_fn) == PIN2_INVERT && !$past(iol_mode_i)
        && $past(cfg_reg.pin1_preset)
        |-> pin2_o == ~pin1_o && pin2_oe_o)
        else $error("Pin 2 is not the complement of pin 1.");

    iol_line_a: assert property (
        iol_mode_i |=> pin1_o == $past(iol_tx_i) && state_reg == OUT_IDLE)
        else $error("Pin 1 not handed to the IO-Link line.");

    iol_lock_a: assert property (
        iol_mode_i && !iol_wr_i |=> $stable(cfg_reg) && $stable(preset_reg))
        else $error("Manual write changed settings in IO-Link mode.");

    short_flag_a: assert property (
        $rose(short_reg) |-> status_reg[STAT_SHORT])
        else $error("Short fault not reported in status.");

    hit_once_a: assert property (
        hit_done_reg ##0 no_clear |=> !hit)
        else $error("Preset hit reported twice in one count cycle.");
endmodule

// ===== include/preset_counter_pkg.sv
// Purpose: Shared constants and types of the preset counter output block.
// Assumes: 250 MHz system clock, plain strobe register port.
// Notes: Offsets are byte addresses of 32-bit words.
package preset_counter_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 32;
    localparam int LEN_W = 10;
    localparam int STAT_W = 4;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRESET = 8'h04;
    localparam logic [7:0] OFF_PULSE_LEN = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_PINS = 8'h18;
    // Pulse length is held in tenths of a second.
    localparam logic [LEN_W-1:0] LEN_MIN = 10'h001;
    localparam logic [LEN_W-1:0] LEN_MAX = 10'h3E8;
    localparam logic [LEN_W-1:0] LEN_RESET = 10'h00A;
    localparam logic [CNT_W-1:0] PRESET_RESET = 32'h0000_0064;
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint TENTH_SEC_PS = 64'd100_000_000_000;
    localparam int TENTH_CYCLES = int'(TENTH_SEC_PS / CLK_PERIOD_PS);
    localparam int SHORT_TIME_NS = 10_000;
    localparam int SHORT_CYCLES = (SHORT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STAT_HIT = 0;
    localparam int STAT_PEND = 1;
    localparam int STAT_CLR = 2;
    localparam int STAT_SHORT = 3;
    typedef enum logic [1:0] {
        PIN2_OFF = 2'b00,
        PIN2_RESET = 2'b01,
        PIN2_INVERT = 2'b10
    } pin2_fn_e;
    typedef enum logic [1:0] {
        RST_RISE = 2'b00,
        RST_FALL = 2'b01,
        RST_HIGH = 2'b10,
        RST_LOW = 2'b11
    } rst_mode_e;
    typedef enum logic [2:0] {
        OUT_IDLE = 3'b001,
        OUT_LATCH = 3'b010,
        OUT_PULSE = 3'b100
    } out_state_e;
    typedef struct packed {
        logic pin1_pp;
        rst_mode_e rst_mode;
        pin2_fn_e pin2_fn;
        logic pin1_preset;
        logic pol_neg;
        logic pulse_mode;
    } cfg_s;
    localparam int CFG_W = $bits(cfg_s);
    localparam cfg_s CFG_RESET = cfg_s'(8'h04);
    typedef struct packed {
        logic [1:0] rise;
        logic [1:0] fall;
        logic [1:0] level;
    } pin_sense_s;
endpackage

// ===== design/pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for both pins.
// Assumes: Pin levels are asynchronous to the system clock.
// Notes: Edges are derived only from the second stage and its delayed copy.
`timescale 1ns/1ps
module pin_sync (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] pin_i,
    output preset_counter_pkg::pin_sense_s sense_o
);
    import preset_counter_pkg::*;
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] prev_reg;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 2'h0;
            sync_reg <= 2'h0;
            prev_reg <= 2'h0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign sense_o = pin_sense_s'{
        rise: sync_reg & ~prev_reg,
        fall: ~sync_reg & prev_reg,
        level: sync_reg
    };

    sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i, 3) |-> sync_reg == $past(pin_i, 2))
        else $error("Synchronised level does not follow the pin two cycles later.");
endmodule

// ===== design/pulse_timer.sv
// Purpose: Times the output pulse in tenths of a second.
// Assumes: Start arrives only while idle; abort ends a pulse early.
// Notes: TICK_CYCLES is a parameter so simulation can shorten a tenth.
`timescale 1ns/1ps
module pulse_timer #(
    parameter int TICK_CYCLES = preset_counter_pkg::TENTH_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [preset_counter_pkg::LEN_W-1:0] len_i,
    output logic done_o
);
    import preset_counter_pkg::*;
    logic busy_reg;
    logic [31:0] tick_reg;
    logic [LEN_W-1:0] left_reg;
    logic tick_end;

    assign tick_end = (tick_reg == 32'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            tick_reg <= 32'h0000_0000;
            left_reg <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                busy_reg <= 1'b1;
                tick_reg <= 32'h0000_0000;
                left_reg <= len_i;
            end else if (abort_i) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                tick_reg <= tick_end ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
                if (tick_end) begin
                    left_reg <= left_reg - LEN_W'(1);
                    if (left_reg == LEN_W'(1)) begin
                        busy_reg <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ===== tb/ctrl_model.sv
// Purpose: Controller on the far side: reads pin 1 and drives the reset input on pin 2.
// Assumes: Both lines have pull-ups at the controller's inputs.
// Notes: short_i ties pin 2 to ground, as a badly wired master would.
`timescale 1ns/1ps
module ctrl_model (
    input wire logic pin1_o,
    input wire logic pin1_oe_o,
    input wire logic pin2_o,
    input wire logic pin2_oe_o,
    input wire logic drv_i,
    input wire logic lvl_i,
    input wire logic short_i,
    output logic pin1_line_o,
    output logic pin2_line_o
);
    // A released line reads as the pull-up, never as the last driven value.
    assign pin1_line_o = pin1_oe_o ? pin1_o : 1'b1;
    assign pin2_line_o = short_i ? 1'b0 : (drv_i ? lvl_i : (pin2_oe_o ? pin2_o : 1'b1));
endmodule

// ===== tb/preset_counter_output_tb_top.sv
// Purpose: Self-checking bench of the preset counter output block.
// Assumes: Pulse tenths shortened to TICK cycles.
// Notes: Pin 2 is driven by the controller model except while it inverts pin 1.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module preset_counter_output_tb_top;
    import preset_counter_pkg::*;
    localparam int TICK = 4;
    logic clk, rst_n, wr, rd, iol_wr, iol_mode, iol_tx, iol_txen, iol_rx, cnt_p;
    logic pin1_line, pin1_o, pin1_oe, pin2_line, pin2_o, pin2_oe, irq, drv, lvl, short_g;
    logic [7:0] addr, iol_addr;
    logic [31:0] wdata, iol_wdata, rdata, d;
    int errors, n_tests, n;
    preset_counter_output #(.TICK_CYCLES(TICK)) i_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .iol_addr_i(iol_addr), .iol_wdata_i(iol_wdata), .iol_wr_i(iol_wr),
        .iol_mode_i(iol_mode), .iol_tx_i(iol_tx), .iol_txen_i(iol_txen), .iol_rx_o(iol_rx),
        .count_pulse_i(cnt_p), .pin1_i(pin1_line), .pin1_o(pin1_o), .pin1_oe_o(pin1_oe),
        .pin2_i(pin2_line), .pin2_o(pin2_o), .pin2_oe_o(pin2_oe), .irq_o(irq));
    ctrl_model i_ctrl (.pin1_o(pin1_o), .pin1_oe_o(pin1_oe), .pin2_o(pin2_o),
        .pin2_oe_o(pin2_oe), .drv_i(drv), .lvl_i(lvl), .short_i(short_g),
        .pin1_line_o(pin1_line), .pin2_line_o(pin2_line));
    task automatic summarize();
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic iol_wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        iol_addr <= a;
        iol_wdata <= v;
        iol_wr <= 1'b1;
        @(posedge clk);
        iol_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rreg(a, v);
        `CHK(nm, e, v)
    endtask
    task automatic pulses(input int c);
        repeat (c) begin
            @(posedge clk);
            cnt_p <= 1'b1;
            @(posedge clk);
            cnt_p <= 1'b0;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run is some 3000 cycles; this bound only catches a hang.
    initial begin
        #200_000;
        errors++;
        summarize();
    end
    initial begin
        {rst_n, wr, rd, iol_wr, iol_mode, iol_tx, iol_txen, cnt_p, lvl, short_g} = '0;
        {addr, iol_addr, wdata, iol_wdata} = '0;
        drv = 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl", OFF_CTRL, 32'(CFG_RESET));
        rchk("preset", OFF_PRESET, PRESET_RESET);
        rchk("length", OFF_PULSE_LEN, {22'h0, LEN_RESET});
        rchk("mask", OFF_MASK, 32'h0000_0000);
        rchk("unmapped", 8'h1C, 32'h0000_0000);
        wreg(OFF_PRESET, 32'h0000_1000);
        // Table of reset modes: even modes idle low, odd modes idle high.
        for (int m = 0; m < 4; m++) begin
            lvl <= m[0];
            wreg(OFF_CTRL, 32'h0000_000C | 32'(m << 5));
            cyc(4);
            pulses(3);
            lvl <= ~m[0];
            cyc(4);
            rchk("cleared", OFF_COUNT, 32'h0000_0000);
            pulses(2);
            rchk("held", OFF_COUNT, m < 2 ? 32'h0000_0002 : 32'h0000_0000);
            lvl <= m[0];
            cyc(4);
            pulses(1);
            rchk("resume", OFF_COUNT, m < 2 ? 32'h0000_0003 : 32'h0000_0001);
        end
        lvl <= 1'b0;
        wreg(OFF_CTRL, 32'h0000_000C);
        cyc(4);
        lvl <= 1'b1;
        cyc(4);
        pulses(3);
        rreg(OFF_STATUS, d);
        cyc(3);
        `CHK("idle", 1'b0, pin1_line)
        wreg(OFF_PRESET, 32'h0000_0002);
        cyc(3);
        `CHK("static on", 1'b1, pin1_line)
        `CHK("masked irq", 1'b0, irq)
        rchk("pins", OFF_PINS, 32'h0000_001B);
        rchk("hit", OFF_STATUS, 32'h0000_0001);
        pulses(2);
        rchk("once", OFF_STATUS, 32'h0000_0000);
        `CHK("static hold", 1'b1, pin1_line)
        lvl <= 1'b0;
        cyc(4);
        lvl <= 1'b1;
        cyc(6);
        `CHK("static off", 1'b0, pin1_line)
        wreg(OFF_CTRL, 32'h0000_0014);
        drv <= 1'b0;
        wreg(OFF_MASK, 32'h0000_0008);
        cyc(4);
        `CHK("inverted idle", 2'b01, {pin1_line, pin2_line})
        short_g <= 1'b1;
        cyc(SHORT_CYCLES + 100);
        `CHK("short irq", 1'b1, irq)
        short_g <= 1'b0;
        cyc(2);
        rreg(OFF_STATUS, d);
        `CHK("short flag", 1'b1, d[STAT_SHORT])
        cyc(2);
        `CHK("irq cleared", 1'b0, irq)
        pulses(2);
        cyc(4);
        `CHK("inverted on", 2'b10, {pin1_line, pin2_line})
        drv <= 1'b1;
        lvl <= 1'b0;
        wreg(OFF_PULSE_LEN, 32'h0000_0000);
        rchk("length min", OFF_PULSE_LEN, {22'h0, LEN_MIN});
        wreg(OFF_PULSE_LEN, 32'h0000_07FF);
        rchk("length max", OFF_PULSE_LEN, {22'h0, LEN_MAX});
        wreg(OFF_PULSE_LEN, 32'h0000_0002);
        wreg(OFF_CTRL, 32'h0000_000F);
        cyc(4);
        lvl <= 1'b1;
        cyc(6);
        `CHK("negative idle", 1'b1, pin1_line)
        pulses(2);
        n = 0;
        while (pin1_line !== 1'b0 && n < 10) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (pin1_line === 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        `CHK("pulse span", 1'b1, n >= 2 * TICK && n <= 2 * TICK + 1)
        wreg(OFF_CTRL, 32'h0000_0084);
        iol_mode <= 1'b1;
        iol_txen <= 1'b1;
        cyc(3);
        `CHK("line low", 2'b10, {pin1_oe, pin1_line})
        iol_tx <= 1'b1;
        cyc(5);
        `CHK("line high", 2'b11, {pin1_line, iol_rx})
        wreg(OFF_PRESET, 32'h0000_0005);
        rchk("bus refused", OFF_PRESET, 32'h0000_0002);
        iol_wreg(OFF_PRESET, 32'h0000_0009);
        rchk("line preset", OFF_PRESET, 32'h0000_0009);
        // High-level hold clears the one-shot, so only IO-Link gating can stop a hit.
        iol_wreg(OFF_CTRL, 32'h0000_00CC);
        cyc(4);
        lvl <= 1'b0;
        cyc(4);
        rreg(OFF_STATUS, d);
        pulses(12);
        cyc(3);
        rchk("line count", OFF_COUNT, 32'h0000_000C);
        rreg(OFF_STATUS, d);
        `CHK("no hit", 1'b0, d[STAT_HIT])
        summarize();
    end
endmodule
